// File: cwrc_pkg.sv
// Functional notes
// - Program protection on when config bit 6 is 0.
// - Bit 5 high: pin resets; low: digital input, no pin reset.
// - Power-up timer on when config bit 4 is 0.
// - Bit 3 high: watchdog on; low: software bit decides.
// - Three-bit oscillator select picks one of eight sources.
// - Brown-out enable never enables the power-up timer.
// - Data protection off erases all data memory.
// - Program protection off erases all program memory.
// - Pin reset in internal or RC modes stops the internal oscillator.
// - Six causes: power-on, watchdog run/sleep, pin run/sleep, brown-out.
// - Retained registers unknown after power-on, kept through other resets.
// - Other registers reset on power-on, pin, watchdog, brown-out.
// - Watchdog wake-up from sleep loads no reset values.
// - Timeout and power-down flags encode the reset cause.
// - Short reset pin pulses are ignored.
// - Watchdog reset never drives the reset pin.
// - Pin select low: reset made internally, pin ignored.
// - Pin select high: weak pull-up on the pin.
// - Power-on detector holds reset until supply is adequate.
// - Enabled brown-out holds reset until supply exceeds threshold.
// - Calibration word survives bulk erase.
// - Brown-out select: 11 on, 10 on except sleep, 01 software, 00 off.
// - Enabled power-up timer holds reset after power-on or brown-out.
package cwrc_pkg;
    localparam int unsigned CFG_WIDTH = 16;
    localparam int unsigned CFG_OSC_SEL_LSB = 0;
    localparam int unsigned CFG_WDT_EN_BIT = 3;
    localparam int unsigned CFG_PWRUP_EN_BIT = 4;
    localparam int unsigned CFG_PIN_SEL_BIT = 5;
    localparam int unsigned CFG_PROG_PROT_BIT = 6;
    localparam int unsigned CFG_DATA_PROT_BIT = 7;
    localparam int unsigned CFG_BOR_SEL_LSB = 8;
    localparam logic [CFG_WIDTH-1:0] CFG_UNIMPL_MASK = 16'hF000;
    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 16'hFFFF;
    localparam logic [CFG_WIDTH-1:0] CAL_RESET = 16'h0000;
    localparam logic TO_RESET = 1'h1;
    localparam logic PD_RESET = 1'h1;

    typedef enum logic [2:0] {
        OSC_LP_XTAL = 3'h0,
        OSC_STD_XTAL = 3'h1,
        OSC_HS_XTAL = 3'h2,
        OSC_EXT_CLK = 3'h3,
        OSC_INT_IO = 3'h4,
        OSC_INT_CLOCK_OUTPUT_PIN = 3'h5,
        OSC_RC_IO = 3'h6,
        OSC_RC_CLOCK_OUTPUT_PIN = 3'h7
    } cwrc_osc_t;

    localparam logic [1:0] BOR_SEL_OFF = 2'h0;
    localparam logic [1:0] BOR_SEL_SW = 2'h1;
    localparam logic [1:0] BOR_SEL_RUN = 2'h2;
    localparam logic [1:0] BOR_SEL_ON = 2'h3;

    typedef enum logic [2:0] {
        CAUSE_POR,
        CAUSE_WDT_RUN,
        CAUSE_WDT_SLEEP,
        CAUSE_PIN_RUN,
        CAUSE_PIN_SLEEP,
        CAUSE_BOR
    } cwrc_cause_t;

    localparam int unsigned CLK_FREQ_KHZ = 200000;
    localparam int unsigned PWRUP_DELAY_MS = 64;
    localparam int unsigned PWRUP_DELAY_CYCLES = PWRUP_DELAY_MS * CLK_FREQ_KHZ;
    localparam int unsigned PWRUP_CNT_W = 24;
    localparam int unsigned PIN_FILTER_NS = 100;
    localparam int unsigned PIN_FILTER_CYCLES = (PIN_FILTER_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int unsigned FILTER_CNT_W = 8;
endpackage

// File: cwrc_pin_filter.sv
module cwrc_pin_filter
    import cwrc_pkg::*;
(
    input wire logic clk_sys_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic pin_i, // Raw pin level
    output logic sync_o, // Synchronised pin level
    output logic filt_o // Filtered pin level
);
    logic meta_q;
    logic sync_q;
    logic filt_q;
    logic [FILTER_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'h1;
            sync_q <= 1'h1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    // A level change must persist for the full window before it is taken
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            filt_q <= 1'h1;
        end else if (sync_q == filt_q) begin
            cnt_q <= '0;
        end else if (cnt_q == FILTER_CNT_W'(PIN_FILTER_CYCLES - 1)) begin
            cnt_q <= '0;
            filt_q <= sync_q;
        end else begin
            cnt_q <= cnt_q + FILTER_CNT_W'(1);
        end
    end

    assign sync_o = sync_q;
    assign filt_o = filt_q;
endmodule

// File: cwrc_powerup_timer.sv
module cwrc_powerup_timer
    import cwrc_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = PWRUP_DELAY_CYCLES
) (
    input wire logic clk_sys_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic enable_i, // Timer enabled by configuration
    input wire logic hold_i, // Power-on or brown-out reset active
    output logic busy_o // Timer holding the chip in reset
);
    logic [PWRUP_CNT_W-1:0] cnt_q;
    logic busy_q;

    // Reloads while held, so a new brown-out restarts the whole delay
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            busy_q <= 1'h0;
        end else if (hold_i) begin
            cnt_q <= PWRUP_CNT_W'(DELAY_CYCLES - 1);
            busy_q <= enable_i;
        end else if (busy_q && cnt_q == '0) begin
            busy_q <= 1'h0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - PWRUP_CNT_W'(1);
        end
    end

    assign busy_o = busy_q;
endmodule

// File: cwrc_top.sv
module cwrc_top
    import cwrc_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = PWRUP_DELAY_CYCLES
) (
    input wire logic clk_sys_i, // System clock, 200 MHz
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic [CFG_WIDTH-1:0] config_word_i, // Configuration word from fuses
    input wire logic software_watchdog_enable_i, // Software watchdog enable bit
    input wire logic software_brownout_enable_i, // Software brown-out enable bit
    input wire logic external_reset_pin_i, // Shared reset pin, reset when low
    input wire logic por_ready_i, // Power-on detector: supply adequate
    input wire logic brownout_ok_i, // Supply above brown-out threshold
    input wire logic watchdog_timeout_i, // Watchdog expiry pulse
    input wire logic sleep_i, // Core is in sleep
    input wire logic retain_ack_i, // Software marks retained regs valid
    input wire logic cal_write_i, // Load calibration word
    input wire logic [CFG_WIDTH-1:0] cal_data_i, // Calibration word data
    output logic [CFG_WIDTH-1:0] config_word_o, // Configuration word read-back
    output logic program_protect_o, // Program memory protected
    output logic data_protect_o, // Data memory protected
    output logic program_erase_o, // Erase all program memory, pulse
    output logic data_erase_o, // Erase all data memory, pulse
    output logic power_up_delay_en_o, // Power-up delay timer enabled
    output logic watchdog_en_o, // Watchdog running
    output logic brownout_en_o, // Brown-out detection active
    output logic [2:0] osc_select_o, // Selected clock source
    output logic clock_output_pin_en_o, // Clock output driven on its pin
    output logic internal_osc_run_o, // Internal oscillator may run
    output logic reset_pin_pullup_o, // Weak pull-up on reset pin
    output logic reset_pin_oe_o, // Reset pin output enable
    output logic port_pin_three_o, // Pin level as digital input
    output logic chip_reset_o, // Chip reset, active high
    output logic [2:0] reset_cause_o, // Last reset cause
    output logic regs_reset_o, // Load register reset values, pulse
    output logic wake_o, // Watchdog wake-up, pulse
    output logic retained_stale_o, // Retained regs unknown since power-on
    output logic timeout_flag_o, // Timeout status flag
    output logic powerdown_flag_o, // Power-down status flag
    output logic [CFG_WIDTH-1:0] calibration_word_o // Calibration word
);
    logic [CFG_WIDTH-1:0] cfg_q;

    logic pin_sync;
    logic pin_filt;

    logic pin_sel;
    logic pin_assert;

    logic [1:0] bor_sel;
    logic bor_en;

    logic por_act;

    logic bor_act;

    logic wdt_en;

    logic wdt_rst_ev;

    logic wdt_wake_ev;

    logic timer_busy;

    logic reset_src;

    logic rst_entry;

    logic osc_int_or_rc;
    cwrc_osc_t osc_mode;

    cwrc_cause_t cause_d;

    logic chip_reset_q;

    logic [2:0] cause_q;

    logic regs_reset_q;

    logic wake_q;

    logic stale_q;

    logic to_q;
    logic pd_q;

    logic prog_prot_q;
    logic data_prot_q;

    logic prog_erase_q;
    logic data_erase_q;

    logic pwrup_en_q;

    logic wdt_en_q;

    logic bor_en_q;

    logic [2:0] osc_q;

    logic clock_output_pin_q;

    logic int_osc_run_q;

    logic pullup_q;

    logic pin_oe_q;

    logic port_pin_q;

    logic [CFG_WIDTH-1:0] cal_q;

    cwrc_pin_filter u_pin_filter (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(external_reset_pin_i),
        .sync_o(pin_sync),
        .filt_o(pin_filt)
    );

    cwrc_powerup_timer #(
        .DELAY_CYCLES(PWRUP_CYCLES)
    ) u_powerup_timer (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(!cfg_q[CFG_PWRUP_EN_BIT]),
        .hold_i(por_act || bor_act),
        .busy_o(timer_busy)
    );

    // Configuration word is read-only; sampled every cycle
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cfg_q <= CFG_RESET;
        end else begin
            cfg_q <= config_word_i;
        end
    end

    always_comb begin
        pin_sel = cfg_q[CFG_PIN_SEL_BIT];
        pin_assert = pin_sel && !pin_filt;
        bor_sel = cfg_q[CFG_BOR_SEL_LSB +: 2];
        case (bor_sel)
            BOR_SEL_ON: bor_en = 1'h1;
            BOR_SEL_RUN: bor_en = !sleep_i;
            BOR_SEL_SW: bor_en = software_brownout_enable_i;
            default: bor_en = 1'h0;
        endcase
        por_act = !por_ready_i;
        bor_act = bor_en && !brownout_ok_i;
        wdt_en = cfg_q[CFG_WDT_EN_BIT] || software_watchdog_enable_i;
        wdt_rst_ev = wdt_en && watchdog_timeout_i && !sleep_i;
        wdt_wake_ev = wdt_en && watchdog_timeout_i && sleep_i;
        reset_src = por_act || bor_act || pin_assert || timer_busy || wdt_rst_ev;
        rst_entry = reset_src && !chip_reset_q;
        osc_mode = cwrc_osc_t'(cfg_q[CFG_OSC_SEL_LSB +: 3]);
        osc_int_or_rc = cfg_q[CFG_OSC_SEL_LSB + 2]; // Modes 100 to 111
        if (por_act) begin
            cause_d = CAUSE_POR;
        end else if (bor_act) begin
            cause_d = CAUSE_BOR;
        end else if (wdt_rst_ev) begin
            cause_d = CAUSE_WDT_RUN;
        end else if (pin_assert && sleep_i) begin
            cause_d = CAUSE_PIN_SLEEP;
        end else begin
            cause_d = CAUSE_PIN_RUN;
        end
    end

    // Release follows the registered source, so it is always clock aligned
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            chip_reset_q <= 1'h1;
            cause_q <= CAUSE_POR;
            regs_reset_q <= 1'h1;
        end else begin
            chip_reset_q <= reset_src;
            regs_reset_q <= rst_entry;
            if (rst_entry || por_act) begin
                cause_q <= cause_d;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wake_q <= 1'h0;
        end else begin
            wake_q <= wdt_wake_ev && !reset_src;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            stale_q <= 1'h1;
        end else if (por_act) begin
            stale_q <= 1'h1;
        end else if (retain_ack_i) begin
            stale_q <= 1'h0;
        end
    end

    // Status flags per cause; pin reset in run leaves both unchanged
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            to_q <= TO_RESET;
            pd_q <= PD_RESET;
        end else if (rst_entry) begin
            case (cause_d)
                CAUSE_POR, CAUSE_BOR: begin
                    to_q <= 1'h1;
                    pd_q <= 1'h1;
                end
                CAUSE_WDT_RUN: to_q <= 1'h0;
                CAUSE_PIN_SLEEP: begin
                    to_q <= 1'h1;
                    pd_q <= 1'h0;
                end
                default: ;
            endcase
        end else if (wdt_wake_ev) begin
            to_q <= 1'h0;
            pd_q <= 1'h0;
        end
    end

    // Protection change from on to off triggers a full erase
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prog_prot_q <= !CFG_RESET[CFG_PROG_PROT_BIT];
            data_prot_q <= !CFG_RESET[CFG_DATA_PROT_BIT];
            prog_erase_q <= 1'h0;
            data_erase_q <= 1'h0;
        end else begin
            prog_prot_q <= !cfg_q[CFG_PROG_PROT_BIT];
            data_prot_q <= !cfg_q[CFG_DATA_PROT_BIT];
            prog_erase_q <= prog_prot_q && cfg_q[CFG_PROG_PROT_BIT];
            data_erase_q <= data_prot_q && cfg_q[CFG_DATA_PROT_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pwrup_en_q <= 1'h0;
            wdt_en_q <= 1'h0;
            bor_en_q <= 1'h0;
        end else begin
            pwrup_en_q <= !cfg_q[CFG_PWRUP_EN_BIT];
            wdt_en_q <= wdt_en;
            bor_en_q <= bor_en;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            osc_q <= CFG_RESET[CFG_OSC_SEL_LSB +: 3];
            clock_output_pin_q <= 1'h1;
            int_osc_run_q <= 1'h1;
        end else begin
            osc_q <= osc_mode;
            clock_output_pin_q <= (osc_mode == OSC_RC_CLOCK_OUTPUT_PIN) || (osc_mode == OSC_INT_CLOCK_OUTPUT_PIN);
            int_osc_run_q <= !(pin_assert && osc_int_or_rc);
        end
    end

    // The pin is input only: no reset source ever drives it
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pullup_q <= 1'h0;
            pin_oe_q <= 1'h0;
            port_pin_q <= 1'h1;
        end else begin
            pullup_q <= pin_sel;
            pin_oe_q <= 1'h0;
            port_pin_q <= pin_sync;
        end
    end

    // No erase path reaches the calibration word
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cal_q <= CAL_RESET;
        end else if (cal_write_i) begin
            cal_q <= cal_data_i;
        end
    end

    assign config_word_o = cfg_q | CFG_UNIMPL_MASK;
    assign program_protect_o = prog_prot_q;
    assign data_protect_o = data_prot_q;
    assign program_erase_o = prog_erase_q;
    assign data_erase_o = data_erase_q;
    assign power_up_delay_en_o = pwrup_en_q;
    assign watchdog_en_o = wdt_en_q;
    assign brownout_en_o = bor_en_q;
    assign osc_select_o = osc_q;
    assign clock_output_pin_en_o = clock_output_pin_q;
    assign internal_osc_run_o = int_osc_run_q;
    assign reset_pin_pullup_o = pullup_q;
    assign reset_pin_oe_o = pin_oe_q;
    assign port_pin_three_o = port_pin_q;
    assign chip_reset_o = chip_reset_q;
    assign reset_cause_o = cause_q;
    assign regs_reset_o = regs_reset_q;
    assign wake_o = wake_q;
    assign retained_stale_o = stale_q;
    assign timeout_flag_o = to_q;
    assign powerdown_flag_o = pd_q;
    assign calibration_word_o = cal_q;
endmodule

// File: cwrc_chk.sv
module cwrc_chk
    import cwrc_pkg::*;
(
    input wire logic clk_sys_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic [CFG_WIDTH-1:0] config_word_i, // Config word
    input wire logic external_reset_pin_i, // Reset pin
    input wire logic por_ready_i, // Supply adequate
    input wire logic brownout_ok_i, // Above brown-out level
    input wire logic watchdog_timeout_i, // Watchdog expiry
    input wire logic sleep_i, // Sleep
    input wire logic program_protect_o, // Protection
    input wire logic program_erase_o, // Erase pulse
    input wire logic power_up_delay_en_o, // Timer enable
    input wire logic brownout_en_o, // Brown-out active
    input wire logic watchdog_en_o, // Watchdog running
    input wire logic [2:0] osc_select_o, // Clock source
    input wire logic clock_output_pin_en_o, // Clock out
    input wire logic internal_osc_run_o, // Oscillator runs
    input wire logic reset_pin_oe_o, // Pin drive
    input wire logic chip_reset_o, // Chip reset
    input wire logic [2:0] reset_cause_o, // Cause
    input wire logic wake_o, // Wake pulse
    input wire logic timeout_flag_o, // Timeout flag
    input wire logic powerdown_flag_o // Power-down flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] warm_q;
    logic [7:0] run_q;
    logic [7:0] peak_q;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // Decode checks wait until the config pipeline holds post-reset values
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) warm_q <= 2'h0;
        else if (warm_q != 2'h3) warm_q <= warm_q + 2'h1;
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || external_reset_pin_i) run_q <= 8'h00;
        else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
    end
    // Longest low run on the pin since the chip last left reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || chip_reset_o) peak_q <= 8'h00;
        else if (run_q > peak_q) peak_q <= run_q;
    end
    property p_prot; &warm_q |-> program_protect_o == !$past(config_word_i[6], 2); endproperty
    a_prot: assert property (p_prot) else $error("protect decode");
    property p_pup; &warm_q |-> power_up_delay_en_o == !$past(config_word_i[4], 2); endproperty
    a_pup: assert property (p_pup) else $error("timer enable");
    property p_osc; &warm_q |-> osc_select_o == $past(config_word_i[2:0], 2); endproperty
    a_osc: assert property (p_osc) else $error("osc select");
    property p_clock_output_pin; clock_output_pin_en_o == (osc_select_o inside {3'h5, 3'h7}); endproperty
    a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock out enable");
    property p_oe; !reset_pin_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("pin driven");
    property p_por; !por_ready_i |=> chip_reset_o && reset_cause_o == CAUSE_POR; endproperty
    a_por: assert property (p_por) else $error("no power-on reset");
    property p_bor; brownout_en_o && !brownout_ok_i && por_ready_i |=> chip_reset_o; endproperty
    a_bor: assert property (p_bor) else $error("no brown-out reset");
    property p_wdt; watchdog_timeout_i && watchdog_en_o && !sleep_i && !chip_reset_o
        && por_ready_i && brownout_ok_i |=> chip_reset_o && reset_cause_o == CAUSE_WDT_RUN
        && !timeout_flag_o ##1 !chip_reset_o; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset");
    property p_wake; watchdog_timeout_i && watchdog_en_o && sleep_i && !chip_reset_o
        && por_ready_i && brownout_ok_i |=> wake_o && !chip_reset_o && !powerdown_flag_o;
    endproperty
    a_wake: assert property (p_wake) else $error("watchdog wake");
    property p_filter; $rose(chip_reset_o) && reset_cause_o inside {CAUSE_PIN_RUN,
        CAUSE_PIN_SLEEP} |-> peak_q >= PIN_FILTER_CYCLES; endproperty
    a_filter: assert property (p_filter) else $error("short pin pulse reset");
    property p_erase; $fell(program_protect_o) |-> ##[0:1] program_erase_o; endproperty
    a_erase: assert property (p_erase) else $error("no program erase");
    property p_osc_stop; !internal_osc_run_o |-> osc_select_o[2]; endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("osc stopped");
endmodule

bind cwrc_top cwrc_chk chk (.*);

// File: cwrc_supply_model.sv
module cwrc_supply_model (
    input wire logic clk_sys_i, // Clock
    input wire logic pin_low_i, // Drive reset pin low
    input wire logic pullup_i, // Device weak pull-up
    input wire logic oe_i, // Device drives pin
    input wire logic supply_ok_i, // Supply above power-on level
    input wire logic above_bor_i, // Supply above brown-out level
    output logic pin_o, // Resolved pin level
    output logic por_ready_o, // Power-on detector
    output logic brownout_ok_o // Brown-out detector
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_q;
    always_ff @(posedge clk_sys_i) float_q <= !(float_q === 1'b1);
    // Released pin goes to the pull-up, else it wanders
    assign pin_o = (pin_low_i || oe_i) ? 1'b0 : (pullup_i ? 1'b1 : float_q);
    assign por_ready_o = supply_ok_i;
    assign brownout_ok_o = above_bor_i;
endmodule

// File: config_word_reset_control_test.sv
module config_word_reset_control_test
    import cwrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PWRUP = 16;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [CFG_WIDTH-1:0] config_word_i = 16'hF0E4;
    logic [CFG_WIDTH-1:0] cal_data_i = 16'h5A3C;
    logic software_watchdog_enable_i = 1'b0;
    logic software_brownout_enable_i = 1'b0;
    logic watchdog_timeout_i = 1'b0;
    logic sleep_i = 1'b0;
    logic retain_ack_i = 1'b0;
    logic cal_write_i = 1'b0;
    logic pin_low = 1'b0;
    logic supply_ok = 1'b1;
    logic above_bor = 1'b1;
    wire external_reset_pin_i;
    wire por_ready_i;
    wire brownout_ok_i;
    logic [CFG_WIDTH-1:0] config_word_o, calibration_word_o;
    logic program_protect_o, data_protect_o, program_erase_o, data_erase_o;
    logic power_up_delay_en_o, watchdog_en_o, brownout_en_o, clock_output_pin_en_o;
    logic [2:0] osc_select_o, reset_cause_o;
    logic internal_osc_run_o, reset_pin_pullup_o, reset_pin_oe_o, port_pin_three_o;
    logic chip_reset_o, regs_reset_o, wake_o, retained_stale_o;
    logic timeout_flag_o, powerdown_flag_o;
    int num_errors = 0;
    int compares = 0;
    int h;
    always #2.5 clk_sys_i = ~clk_sys_i;
    cwrc_top #(.PWRUP_CYCLES(PWRUP)) uut (.*);
    cwrc_supply_model model (.clk_sys_i(clk_sys_i), .pin_low_i(pin_low),
        .pullup_i(reset_pin_pullup_o), .oe_i(reset_pin_oe_o), .supply_ok_i(supply_ok),
        .above_bor_i(above_bor), .pin_o(external_reset_pin_i), .por_ready_o(por_ready_i),
        .brownout_ok_o(brownout_ok_i));
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic set_cfg(input logic [15:0] v);
        @(posedge clk_sys_i);
        config_word_i <= v;
        cyc(3);
    endtask
    task automatic wait_free(output int n);
        n = 0;
        while (chip_reset_o !== 1'b0 && n < 200) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic wdt_pulse();
        @(posedge clk_sys_i);
        watchdog_timeout_i <= 1'b1;
        @(posedge clk_sys_i);
        watchdog_timeout_i <= 1'b0;
        #1;
    endtask
    // Pin low n+1 cycles; counts chip reset cycles in the first n
    task automatic pin_low_for(input int n, output int hits);
        hits = 0;
        @(posedge clk_sys_i);
        pin_low <= 1'b1;
        repeat (n) begin
            cyc(1);
            hits += int'(chip_reset_o === 1'b1);
        end
        @(posedge clk_sys_i);
        pin_low <= 1'b0;
        #1;
    endtask
    task automatic t_decode();
        logic [15:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {4'hF, 2'h0, i[1:0], (i[0] ? 5'h1F : 5'h00), i[2:0]};
            software_brownout_enable_i <= i[2];
            set_cfg(v);
            check("osc_select_o", 16'(i[2:0]), 16'(osc_select_o));
            check("clock_output_pin_en_o", 16'(i == 5 || i == 7), 16'(clock_output_pin_en_o));
            check("program_protect_o", 16'(!i[0]), 16'(program_protect_o));
            check("data_protect_o", 16'(!i[0]), 16'(data_protect_o));
            check("config_word_o", v, config_word_o);
            check("power_up_delay_en_o", 16'(!i[0]), 16'(power_up_delay_en_o));
            check("reset_pin_pullup_o", 16'(i[0]), 16'(reset_pin_pullup_o));
            check("watchdog_en_o", 16'(i[0]), 16'(watchdog_en_o));
            check("brownout_en_o", 16'(i[1] || (i[0] && i[2])), 16'(brownout_en_o));
        end
    endtask
    task automatic t_por();
        int n;
        @(posedge clk_sys_i);
        supply_ok <= 1'b0;
        cyc(1);
        check("regs_reset_o", 16'h1, 16'(regs_reset_o));
        cyc(30);
        check("chip_reset_o", 16'h1, 16'(chip_reset_o));
        check("reset_cause_o", 16'(CAUSE_POR), 16'(reset_cause_o));
        check("flags", 16'h3, 16'({timeout_flag_o, powerdown_flag_o}));
        check("retained_stale_o", 16'h1, 16'(retained_stale_o));
        @(posedge clk_sys_i);
        supply_ok <= 1'b1;
        cyc(1);
        wait_free(n);
        check("power_up_delay_span", 16'h1, 16'(n >= PWRUP && n <= PWRUP + 3));
        @(posedge clk_sys_i);
        retain_ack_i <= 1'b1;
        @(posedge clk_sys_i);
        retain_ack_i <= 1'b0;
        cyc(1);
        check("retained_stale_o", 16'h0, 16'(retained_stale_o));
    endtask
    task automatic t_wdt();
        set_cfg(16'hF0EC);
        wdt_pulse();
        check("chip_reset_o", 16'h1, 16'(chip_reset_o));
        check("reset_cause_o", 16'(CAUSE_WDT_RUN), 16'(reset_cause_o));
        check("flags", 16'h1, 16'({timeout_flag_o, powerdown_flag_o}));
        check("regs_reset_o", 16'h1, 16'(regs_reset_o));
        check("retained_stale_o", 16'h0, 16'(retained_stale_o));
        check("reset_pin_oe_o", 16'h0, 16'(reset_pin_oe_o));
        cyc(1);
        check("chip_reset_o", 16'h0, 16'(chip_reset_o));
        sleep_i <= 1'b1;
        wdt_pulse();
        check("wake_o", 16'h1, 16'(wake_o));
        check("regs_reset_o", 16'h0, 16'(regs_reset_o));
        check("flags", 16'h0, 16'({timeout_flag_o, powerdown_flag_o}));
        sleep_i <= 1'b0;
        set_cfg(16'hF0E4);
        wdt_pulse();
        check("chip_reset_o", 16'h0, 16'(chip_reset_o));
        software_watchdog_enable_i <= 1'b1;
        cyc(2);
        check("watchdog_en_o", 16'h1, 16'(watchdog_en_o));
        software_watchdog_enable_i <= 1'b0;
    endtask
    task automatic t_pin();
        pin_low_for(10, h);
        cyc(30);
        check("short_pulse_resets", 16'h0, 16'(h + int'(chip_reset_o === 1'b1)));
        pin_low_for(30, h);
        check("chip_reset_o", 16'h1, 16'(chip_reset_o));
        check("reset_cause_o", 16'(CAUSE_PIN_RUN), 16'(reset_cause_o));
        check("internal_osc_run_o", 16'h0, 16'(internal_osc_run_o));
        check("flags", 16'h0, 16'({timeout_flag_o, powerdown_flag_o}));
        wait_free(h);
        sleep_i <= 1'b1;
        pin_low_for(30, h);
        check("reset_cause_o", 16'(CAUSE_PIN_SLEEP), 16'(reset_cause_o));
        check("flags", 16'h2, 16'({timeout_flag_o, powerdown_flag_o}));
        sleep_i <= 1'b0;
        wait_free(h);
        set_cfg(16'hF0C4);
        pin_low_for(30, h);
        check("port_pin_three_o", 16'h0, 16'(port_pin_three_o));
        check("pin_select_off_resets", 16'h0, 16'(h));
        set_cfg(16'hF0E4);
        wait_free(h);
    endtask
    task automatic t_bor();
        int n;
        set_cfg(16'hF3F4);
        above_bor <= 1'b0;
        cyc(2);
        check("chip_reset_o", 16'h1, 16'(chip_reset_o));
        check("reset_cause_o", 16'(CAUSE_BOR), 16'(reset_cause_o));
        check("flags", 16'h3, 16'({timeout_flag_o, powerdown_flag_o}));
        above_bor <= 1'b1;
        cyc(1);
        wait_free(n);
        check("fast_release_no_timer", 16'h1, 16'(n <= 3));
        set_cfg(16'hF024);
    endtask
    task automatic t_erase();
        int p = 0;
        int d = 0;
        cal_write_i <= 1'b1;
        @(posedge clk_sys_i);
        cal_write_i <= 1'b0;
        config_word_i <= 16'hF0E4;
        repeat (5) begin
            cyc(1);
            p += int'(program_erase_o === 1'b1);
            d += int'(data_erase_o === 1'b1);
        end
        check("program_erase_o", 16'h1, 16'(p));
        check("data_erase_o", 16'h1, 16'(d));
        check("calibration_word_o", cal_data_i, calibration_word_o);
    endtask
    task automatic complete_run();
        $display("compares %0d, num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        cyc(3);
        wait_free(h);
        t_decode();
        set_cfg(16'hF0E4);
        wait_free(h);
        t_por();
        t_wdt();
        t_pin();
        t_bor();
        @(posedge clk_sys_i);
        t_erase();
        complete_run();
    end
endmodule
